/* File: logic/bkg_pkg.sv */
`default_nettype none
package bkg_pkg;
   // register map (byte addresses on the bus)
   localparam logic [3:0] UNLOCK_OFFSET  = 4'h0;  // unlock key, write only
   localparam logic [3:0] CONTROL_OFFSET = 4'h4;  // option bits, exit request
   localparam logic [3:0] STATUS_OFFSET  = 4'h8;  // execution state, read only

   // unlock key compared against bits 7..2 of the written byte
   localparam logic [5:0] UNLOCK_KEY     = 6'h26;  // 100110
   localparam int         KEY_MSB        = 7;
   localparam int         KEY_LSB        = 2;

   // unlock window and force-pin debounce, in instruction cycles
   localparam int         UNLOCK_CYCLES  = 8;
   localparam int         DEBOUNCE_CYCLES = 4;

   // control register field positions
   localparam int         CTL_FLASH_EXEC = 0;
   localparam int         CTL_SECURITY   = 1;
   localparam int         CTL_EXIT       = 2;
   localparam int         CTL_MASS_ERASE = 3;
   localparam int         CTL_USER_CLEAR = 4;

   // reset values of the non-volatile option image
   localparam logic       FLASH_EXEC_RST = 1'b1;
   localparam logic       SECURITY_RST   = 1'b0;

   localparam logic [15:0] START_ADDR    = 16'h0000;

   typedef enum logic [1:0] {
      MEM_FLASH,
      MEM_BOOT
   } bkg_mem_type;
endpackage
`default_nettype wire

/* File: logic/bkg_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module bkg_sync (
   input  wire logic mclk,   // clock
   input  wire logic din,    // asynchronous level
   output logic      dout    // synchronised level
);
   logic stage1Q;
   logic stage2Q;

   // no reset: the pin level must already be through both stages
   // at the first edge after reset release
   always_ff @(posedge mclk) begin
      stage1Q <= din;
      stage2Q <= stage1Q;
   end

   assign dout = stage2Q;
endmodule
`default_nettype wire

/* File: logic/bkg_gate.sv */
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------------------
module bkg_gate
   import bkg_pkg::*;
#(
   parameter int ADDR_W = 16           // program address width
) (
   input  wire logic              mclk,            // 125 MHz clock
   input  wire logic              rst_n,           // sync reset, low
   // axi4-lite slave
   input  wire logic [3:0]        s_axi_awaddr,    // write address
   input  wire logic              s_axi_awvalid,   // write addr valid
   output logic                   s_axi_awready,   // write addr ready
   input  wire logic [31:0]       s_axi_wdata,     // write data
   input  wire logic [3:0]        s_axi_wstrb,     // byte enables
   input  wire logic              s_axi_wvalid,    // write data valid
   output logic                   s_axi_wready,    // write data ready
   output logic [1:0]             s_axi_bresp,     // write response
   output logic                   s_axi_bvalid,    // response valid
   input  wire logic              s_axi_bready,    // response ready
   input  wire logic [3:0]        s_axi_araddr,    // read address
   input  wire logic              s_axi_arvalid,   // read addr valid
   output logic                   s_axi_arready,   // read addr ready
   output logic [31:0]            s_axi_rdata,     // read data
   output logic [1:0]             s_axi_rresp,     // read response
   output logic                   s_axi_rvalid,    // read data valid
   input  wire logic              s_axi_rready,    // read data ready
   // core instruction flow
   input  wire logic              jump_to_boot_instr,   // exec strobe
   input  wire logic              return_to_flash_instr,// exec strobe
   input  wire logic [ADDR_W-1:0] jumpTarget,      // jump target
   input  wire logic              emuBreak,        // breakpoint active
   output logic                   pcLoad,          // load pc pulse
   output logic [ADDR_W-1:0]      pcValue,         // new pc
   output logic                   execBoot,        // 1 = boot ROM
   output logic                   unlockFlag,      // unlock window open
   // pins
   input  wire logic              force_boot_pin,  // raised-level detect
   input  wire logic              loadClock,       // internal load clock
   output logic                   load_clock_out_pin,   // clock out
   output logic                   loadClockOe,     // clock out enable
   output logic                   forceBootIn,     // digital pin value
   output logic                   ispEnable,       // serial ISP enabled
   output logic                   resetRequest     // self reset pulse
);
   // ------------------------------------------------------------
   // pin synchroniser and helpers
   // ------------------------------------------------------------
   logic forceSync;

   bkg_sync u_force_sync (
      .mclk  (mclk),
      .din   (force_boot_pin),
      .dout  (forceSync)
   );

   function automatic logic key_match(input logic [7:0] b);
      key_match = (b[KEY_MSB:KEY_LSB] == UNLOCK_KEY);
   endfunction

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   logic        awHeld_q;
   logic [3:0]  awAddr_q;
   logic        wHeld_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        bValid_q;
   logic        wrFire;

   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready  = !wHeld_q && !bValid_q;
   assign wrFire        = awHeld_q && wHeld_q && !bValid_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = 2'h0;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wHeld_q <= 1'b0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end else if (wrFire) begin
         wHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n)
         bValid_q <= 1'b0;
      else if (wrFire)
         bValid_q <= 1'b1;
      else if (s_axi_bready)
         bValid_q <= 1'b0;
   end

   logic keyWrite;
   logic ctlWrite;
   assign keyWrite = wrFire && wStrb_q[0] && (awAddr_q == UNLOCK_OFFSET);
   assign ctlWrite = wrFire && wStrb_q[0] && (awAddr_q == CONTROL_OFFSET);

   // ------------------------------------------------------------
   // unlock window
   // ------------------------------------------------------------
   // the counter runs through interrupt service too, so a long
   // handler lets the window lapse before the jump is reached
   logic       unlock_q;
   logic [3:0] unlockCnt_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         unlock_q    <= 1'b0;
         unlockCnt_q <= 4'h0;
      end else if (keyWrite && key_match(wData_q[7:0])) begin
         unlock_q    <= 1'b1;
         unlockCnt_q <= 4'(UNLOCK_CYCLES - 1);
      end else if (keyWrite) begin
         unlock_q    <= 1'b0;
         unlockCnt_q <= 4'h0;
      end else if (unlock_q && !emuBreak) begin
         if (unlockCnt_q == 4'h0)
            unlock_q <= 1'b0;
         else
            unlockCnt_q <= unlockCnt_q - 4'h1;
      end
   end
   assign unlockFlag = unlock_q;

   // ------------------------------------------------------------
   // option image: flash-exec and security bits
   // ------------------------------------------------------------
   logic flashExec_q;
   logic security_q;
   logic exitReq;
   assign exitReq = ctlWrite && wData_q[CTL_EXIT];

   // forced boot never touches these two bits
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flashExec_q <= FLASH_EXEC_RST;
         security_q  <= SECURITY_RST;
      end else if (ctlWrite) begin
         flashExec_q <= wData_q[CTL_FLASH_EXEC];
         if (wData_q[CTL_SECURITY])
            security_q <= 1'b1;
         else if (wData_q[CTL_MASS_ERASE] || wData_q[CTL_USER_CLEAR])
            security_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // reset entry: forced boot sampled after reset release
   // ------------------------------------------------------------
   // the pin is caught at the first clocked sample after release;
   // the host keeps it raised long enough for the synchroniser
   logic        rstDone_q;
   logic        forcedBoot_q;
   logic        entryPend_q;
   bkg_mem_type mem_q;
   logic        pcLoad_q;
   logic [ADDR_W-1:0] pc_q;

   // entry is a one-shot: a later return to flash at 0000 must not
   // look like a fresh forced reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rstDone_q    <= 1'b0;
         forcedBoot_q <= 1'b0;
         entryPend_q  <= 1'b0;
      end else begin
         rstDone_q    <= 1'b1;
         entryPend_q  <= !rstDone_q && forceSync;
         if (!rstDone_q)
            forcedBoot_q <= forceSync;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mem_q    <= MEM_FLASH;
         pcLoad_q <= 1'b0;
         pc_q     <= '0;
      end else if (entryPend_q) begin
         mem_q    <= MEM_BOOT;
         pcLoad_q <= 1'b1;
         pc_q     <= ADDR_W'(START_ADDR);
      end else if (jump_to_boot_instr) begin
         pcLoad_q <= 1'b1;
         if (unlock_q) begin
            mem_q <= MEM_BOOT;
            pc_q  <= jumpTarget;
         end else begin
            mem_q <= MEM_FLASH;
            pc_q  <= jumpTarget;
         end
      end else if (return_to_flash_instr && mem_q == MEM_BOOT) begin
         mem_q    <= MEM_FLASH;
         pcLoad_q <= 1'b1;
         pc_q     <= jumpTarget;
      end else begin
         pcLoad_q <= 1'b0;
      end
   end

   // ordinary reset (forceBoot low) stays in flash at 0000
   assign execBoot = (mem_q == MEM_BOOT);
   assign pcLoad   = pcLoad_q;
   assign pcValue  = pc_q;

   // ------------------------------------------------------------
   // exit: self reset back into flash
   // ------------------------------------------------------------
   logic resetReq_q;
   always_ff @(posedge mclk) begin
      if (!rst_n)
         resetReq_q <= 1'b0;
      else
         resetReq_q <= exitReq && execBoot && flashExec_q;
   end
   assign resetRequest = resetReq_q;

   // ------------------------------------------------------------
   // force pin: load clock out, input value, debounce
   // ------------------------------------------------------------
   assign load_clock_out_pin = forceSync ? loadClock : 1'b0;
   assign loadClockOe        = forceSync;
   assign forceBootIn        = forceSync;

   logic [2:0] lowCnt_q;
   logic       isp_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lowCnt_q <= 3'h0;
         isp_q    <= 1'b0;
      end else if (!forcedBoot_q || isp_q) begin
         lowCnt_q <= 3'h0;
      end else if (forceSync) begin
         lowCnt_q <= 3'h0;
      end else if (lowCnt_q == 3'(DEBOUNCE_CYCLES - 1)) begin
         isp_q    <= 1'b1;
      end else begin
         lowCnt_q <= lowCnt_q + 3'h1;
      end
   end
   assign ispEnable = isp_q;

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   logic        rValid_q;
   logic [31:0] rData_q;
   logic [1:0]  rResp_q;

   assign s_axi_arready = !rValid_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rValid_q <= 1'b0;
         rData_q  <= 32'h0;
         rResp_q  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_q <= 1'b1;
         rResp_q  <= 2'h0;
         if (s_axi_araddr == CONTROL_OFFSET)
            rData_q <= {30'h0, security_q, flashExec_q};
         else if (s_axi_araddr == STATUS_OFFSET)
            rData_q <= {26'h0, isp_q, forceSync, forcedBoot_q,
                        execBoot, unlock_q, 1'b0};
         else begin
            rData_q <= 32'h0;   // unlock register is write only
            rResp_q <= (s_axi_araddr == UNLOCK_OFFSET) ? 2'h0 : 2'h2;
         end
      end else if (s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: tb/bkg_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bkg_host_model (
   output logic      rst_n,          // device reset, active low
   output logic      force_boot_pin, // raised-level drive
   input  wire logic mclk            // clock
);
   // ordinary reset with the pin left low, n edges long
   task automatic plain_reset(input int n);
      force_boot_pin <= 1'b0;
      rst_n          <= 1'b0;
      repeat (n) @(posedge mclk);
      rst_n <= 1'b1;
   endtask

   // pin raised only once reset is held, released afterwards
   task automatic enter_forced();
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      force_boot_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
   endtask

   task automatic leave_forced();
      repeat (3) @(posedge mclk);
      force_boot_pin <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/bkg_gate_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module bkg_gate_checker
   import bkg_pkg::*;
#(
   parameter int ADDR_W = 16                          // pc width
) (
   input wire logic              mclk,                // clock
   input wire logic              rst_n,               // reset
   input wire logic              jump_to_boot_instr,  // jump strobe
   input wire logic              return_to_flash_instr, // return
   input wire logic [ADDR_W-1:0] jumpTarget,          // target
   input wire logic              emuBreak,            // breakpoint
   input wire logic              pcLoad,              // pc load
   input wire logic [ADDR_W-1:0] pcValue,             // new pc
   input wire logic              execBoot,            // in boot ROM
   input wire logic              unlockFlag,          // window open
   input wire logic              force_boot_pin,      // force pin
   input wire logic              loadClock,           // load clock
   input wire logic              load_clock_out_pin,  // clock out
   input wire logic              loadClockOe,         // out enable
   input wire logic              forceBootIn          // pin value
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // a key rewritten inside an open window does not restart this count
   logic [3:0] openCnt_q;
   always_ff @(posedge mclk) begin
      if (!rst_n || !unlockFlag) begin
         openCnt_q <= 4'h0;
      end else if (!emuBreak) begin
         openCnt_q <= openCnt_q + 4'h1;
      end
   end

   sequence s_forced_release;
      $rose(rst_n) && force_boot_pin;
   endsequence
   sequence s_boot_start;
      pcLoad && execBoot && pcValue == START_ADDR;
   endsequence

   a_unlock_max: assert property (
      openCnt_q <= UNLOCK_CYCLES) else $error("window too long");
   a_break_freeze: assert property (
      unlockFlag && emuBreak |=> unlockFlag)
      else $error("window closed during breakpoint");
   a_jump_boot: assert property (
      jump_to_boot_instr && unlockFlag |=> pcLoad && execBoot)
      else $error("open jump missed boot ROM");
   a_jump_flash: assert property (
      jump_to_boot_instr && !unlockFlag && !execBoot |=> pcLoad
      && !execBoot && pcValue == $past(jumpTarget))
      else $error("closed jump not to flash target");
   a_return_flash: assert property (
      return_to_flash_instr && execBoot |=> pcLoad && !execBoot)
      else $error("return did not reach flash");
   a_clock_out: assert property (
      loadClockOe |-> load_clock_out_pin == loadClock)
      else $error("load clock not on clock out");
   a_pin_reads_one: assert property (
      force_boot_pin [*3] |-> forceBootIn && loadClockOe)
      else $error("raised pin not seen");
   a_forced_entry: assert property (
      s_forced_release |-> ##[1:4] s_boot_start)
      else $error("forced boot did not start at 0000");
   a_plain_start: assert property (
      $rose(rst_n) && !force_boot_pin |-> !execBoot [*4])
      else $error("plain reset left flash");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import bkg_pkg::*;
   logic        mclk, loadClock, emuBreak, jump_to_boot_instr;
   logic        return_to_flash_instr, pcLoad, execBoot, unlockFlag;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, loadClockOe, forceBootIn;
   logic        load_clock_out_pin, ispEnable, resetRequest;
   logic        rst_n, force_boot_pin;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rdResp, wrResp;
   logic [15:0] jumpTarget, pcValue;
   int          errors, checkCount, flagCycles, resetPulses;

   bkg_gate dut (
      .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .jump_to_boot_instr,
      .return_to_flash_instr, .jumpTarget, .emuBreak, .pcLoad, .pcValue,
      .execBoot, .unlockFlag, .force_boot_pin, .loadClock,
      .load_clock_out_pin, .loadClockOe, .forceBootIn, .ispEnable,
      .resetRequest
   );
   bkg_host_model host (.mclk, .rst_n, .force_boot_pin);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // window length is judged from this running count of open cycles
   always @(posedge mclk) begin
      loadClock  <= ~loadClock;
      flagCycles <= flagCycles + int'(unlockFlag);
      resetPulses <= resetPulses + int'(resetRequest);
   end

   task automatic finish_test();
      $display("errors=%0d checks=%0d", errors, checkCount);
      if (errors == 0 && checkCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic timeout();
      errors++;
      finish_test();
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // bus master
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid) break;
      end
      wrResp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) timeout();
      // idle edge so a following call never re-raises bready at once
      @(posedge mclk);
   endtask
   task automatic axi_rd(input logic [3:0] a);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_arvalid) break;
      end
      rdVal = s_axi_rdata;
      rdResp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) timeout();
      @(posedge mclk);
   endtask
   task automatic instr(input logic toBoot);
      jump_to_boot_instr    <= toBoot;
      return_to_flash_instr <= !toBoot;
      @(posedge mclk);
      jump_to_boot_instr    <= 1'b0;
      return_to_flash_instr <= 1'b0;
      #1;
      check(pcLoad, 1'b1);
      @(posedge mclk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check(unlockFlag, 1'b0);
      check(execBoot, 1'b0);
      axi_rd(CONTROL_OFFSET);
      check(rdVal[1:0], 2'b01);
      axi_rd(4'hc);
      check(rdResp, 2'b10);
   endtask
   task automatic t_keys();
      logic [7:0] k [8] = '{8'h98, 8'h99, 8'h9a, 8'h9b,
                            8'h18, 8'hd8, 8'h9c, 8'h00};
      int c;
      foreach (k[i]) begin
         c = flagCycles;
         axi_wr(UNLOCK_OFFSET, {24'h0, k[i]});
         repeat (12) @(posedge mclk);
         check(flagCycles - c,
               (k[i][7:2] == 6'b100110) ? UNLOCK_CYCLES : 0);
      end
   endtask
   task automatic t_jump();
      jumpTarget <= 16'h1234;
      instr(1'b1);
      check(pcValue, 16'h1234);
      check(execBoot, 1'b0);
      axi_wr(UNLOCK_OFFSET, 32'h98);
      instr(1'b1);
      check(execBoot, 1'b1);
      instr(1'b0);
      check(execBoot, 1'b0);
      // let the first window lapse so this key opens a fresh one
      repeat (8) @(posedge mclk);
      axi_wr(UNLOCK_OFFSET, 32'h9a);
      repeat (10) @(posedge mclk);
      instr(1'b1);
      check(execBoot, 1'b0);
   endtask
   task automatic t_break();
      int c;
      c = flagCycles;
      axi_wr(UNLOCK_OFFSET, 32'h9b);
      emuBreak <= 1'b1;
      repeat (5) @(posedge mclk);
      emuBreak <= 1'b0;
      repeat (12) @(posedge mclk);
      check(flagCycles - c, UNLOCK_CYCLES + 5);
   endtask
   task automatic t_security();
      logic [31:0] clr [2] = '{32'h11, 32'h09};
      foreach (clr[i]) begin
         axi_wr(CONTROL_OFFSET, 32'h3);
         check(wrResp, 2'b00);
         axi_wr(CONTROL_OFFSET, 32'h1);
         axi_rd(CONTROL_OFFSET);
         check(rdVal[1], 1'b1);
         axi_wr(CONTROL_OFFSET, clr[i]);
         axi_rd(CONTROL_OFFSET);
         check(rdVal[1], 1'b0);
      end
   endtask
   task automatic t_forced();
      int n;
      int c;
      host.enter_forced();
      for (n = 0; n < 8 && !pcLoad; n++) @(posedge mclk);
      if (n == 8) timeout();
      check(pcValue, START_ADDR);
      check(execBoot, 1'b1);
      check(forceBootIn, 1'b1);
      check(load_clock_out_pin, loadClock);
      check(ispEnable, 1'b0);
      check(loadClockOe, 1'b1);
      axi_rd(STATUS_OFFSET);
      check(rdVal[5:0], 6'h1c);
      axi_rd(CONTROL_OFFSET);
      check(rdVal[1:0], 2'b01);
      host.leave_forced();
      for (n = 0; n < 30 && !ispEnable; n++) @(posedge mclk);
      if (n == 30) timeout();
      c = resetPulses;
      axi_wr(CONTROL_OFFSET, 32'h5);
      for (n = 0; n < 8 && resetPulses == c; n++) @(posedge mclk);
      if (n == 8) timeout();
      check(resetPulses - c, 1);
      host.plain_reset(4);
      repeat (4) @(posedge mclk);
      check(execBoot, 1'b0);
      check(pcValue, 16'h0000);
   endtask

   initial begin
      errors = 0;
      checkCount = 0;
      flagCycles = 0;
      resetPulses = 0;
      {loadClock, emuBreak, jump_to_boot_instr, return_to_flash_instr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, jumpTarget} = '0;
      s_axi_wstrb = 4'hf;
      host.plain_reset(20);
      @(posedge mclk);
      t_reset();
      t_keys();
      t_jump();
      t_break();
      t_security();
      t_forced();
      finish_test();
   end
endmodule

bind bkg_gate bkg_gate_checker #(.ADDR_W(ADDR_W)) chk (
   .mclk, .rst_n, .jump_to_boot_instr, .return_to_flash_instr, .jumpTarget,
   .emuBreak, .pcLoad, .pcValue, .execBoot, .unlockFlag, .force_boot_pin,
   .loadClock, .load_clock_out_pin, .loadClockOe, .forceBootIn
);
`default_nettype wire
